// ==== core/fsl_dev.sv ====
// Flash-side command end: security register read, block locks, soft reset.
// Assumes the link pins are asynchronous to ref_clk_in and the serial
// clock is well below a quarter of ref_clk_in.
//
// Operation
// - Security read: 48h, address, eight dummy clocks
// - Sample on rising, drive MSB first falling
// - Byte address increments, FFh wraps to 00h
// - Security read ignored while busy
// - Register select from address bits 15-12
// - Lock bits protect only when select set
// - All lock bits set after any reset
// - 36h plus address locks one unit
// - 39h plus address unlocks one unit
// - 3Dh plus address returns unit lock
// - Returned LSB one means locked
// - 7Eh alone sets every lock bit
// - 98h alone clears every lock bit
// - Lock commands need write enable latch set
// - Reset needs 66h then 99h frames
// - Other command after 66h disarms reset
// - Reset aborts work, restores volatile defaults
// - No commands during 30us recovery
// - Host checks busy and suspend first; fsl_host sends 66h and 99h without checking either
// - Security read runs until chip select rises
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "fsl_params.svh"

module fsl_dev (
  input wire logic ref_clk_in, // System clock, 10 MHz
  input wire logic reset_n_in, // Synchronous reset, active low
  fsl_spi_if.dev spi, // Serial link to the host end
  input wire logic busy_in, // Erase/program/write cycle running
  input wire logic write_enable_latch_in, // Write enable latch state
  input wire logic per_unit_lock_select_in, // Use per-unit locks
  input wire logic range_protect_in, // Protection from range bits
  input wire logic [4:0] prot_unit_in, // Unit asked about
  input wire logic [7:0] sec_rd_data_in, // Security register byte
  output logic [9:0] sec_rd_addr_out, // Register and byte address
  output logic protected_out, // Asked unit is protected
  output logic [`FSL_LOCK_UNITS-1:0] lock_bits_out, // Lock map
  output logic sw_reset_out, // One-cycle soft reset pulse
  output logic recovering_out // Reset recovery in progress
);

  fsl_pkg::fsl_dev_st_t st_q;
  fsl_pkg::fsl_dev_st_t st_d;

  logic cs_high;
  logic cs_fall;
  logic cs_rise;
  logic ck_rise;
  logic ck_fall;
  logic sec_addr_ok;
  logic [5:0] data_start;
  logic [7:0] out_byte;
  logic [`FSL_LOCK_IDX_MSB-`FSL_LOCK_IDX_LSB:0] unit_idx;

  // ******************************************
  // Pin edges, seen only from the second flop onward
  // ******************************************
  assign cs_high = st_q.cs_s[1];
  assign cs_fall = ~st_q.cs_s[1] & st_q.cs_s[2];
  assign cs_rise = st_q.cs_s[1] & ~st_q.cs_s[2];
  assign ck_rise = ~cs_high & st_q.ck_s[1] & ~st_q.ck_s[2];
  assign ck_fall = ~cs_high & ~st_q.ck_s[1] & st_q.ck_s[2];

  assign unit_idx = st_q.addr[`FSL_LOCK_IDX_MSB:`FSL_LOCK_IDX_LSB];

  // ******************************************
  // Next state
  // ******************************************
  always_comb begin
    st_d = st_q;
    st_d.rst_pulse = 1'b0;
    st_d.cs_s = {st_q.cs_s[1:0], spi.cs_n};
    st_d.ck_s = {st_q.ck_s[1:0], spi.sclk};
    st_d.si_s = {st_q.si_s[0], spi.serial_in};
    sec_addr_ok = 1'b0;
    out_byte = 8'h00;
    data_start = (st_q.opcode == `FSL_OP_SEC_READ) ?
                 `FSL_SEC_START : `FSL_ADDR_END;

    if (st_q.rec_cnt != 9'h000) begin
      st_d.rec_cnt = st_q.rec_cnt - 9'h001;
    end

    if (cs_fall) begin
      // A frame that starts during recovery is ignored whole
      st_d.frame_ok = (st_q.rec_cnt == 9'h000);
    end

    // Command and address bits
    if (ck_rise && st_q.frame_ok) begin
      if (st_q.bit_cnt < `FSL_OPC_BITS) begin
        st_d.opcode = {st_q.opcode[6:0], st_q.si_s[1]};
      end else if (st_q.bit_cnt < `FSL_ADDR_END) begin
        st_d.addr = {st_q.addr[22:0], st_q.si_s[1]};
      end
      if (st_q.bit_cnt != `FSL_SEC_START) begin
        st_d.bit_cnt = st_q.bit_cnt + 6'h01;
      end
      if (st_q.bit_cnt == `FSL_ADDR_END - 6'h01) begin
        sec_addr_ok =
          (st_d.addr[`FSL_SEC_HI_MSB:`FSL_SEC_HI_LSB] == `FSL_SEC_HI_ZERO) &&
          (st_d.addr[`FSL_SEC_MID_MSB:`FSL_SEC_MID_LSB] ==
           `FSL_SEC_MID_ZERO) &&
          (st_d.addr[`FSL_SEC_SEL_MSB:`FSL_SEC_SEL_LSB] >=
           `FSL_SEC_SEL_MIN) &&
          (st_d.addr[`FSL_SEC_SEL_MSB:`FSL_SEC_SEL_LSB] <=
           `FSL_SEC_SEL_MAX);
        st_d.sec_sel = st_d.addr[`FSL_SEC_SEL_LSB+1:`FSL_SEC_SEL_LSB];
        st_d.sec_byte = st_d.addr[`FSL_SEC_BYTE_MSB:0];
        if (st_q.opcode == `FSL_OP_SEC_READ) begin
          st_d.rd_ok = sec_addr_ok & ~busy_in;
        end else begin
          st_d.rd_ok = (st_q.opcode == `FSL_OP_LOCK_READ);
        end
      end
    end

    // Read data, one bit per falling edge, MSB first
    if (ck_fall && st_q.frame_ok && st_q.rd_ok &&
        st_q.bit_cnt >= data_start) begin
      if (st_q.tx_idx == 3'h0) begin
        if (st_q.opcode == `FSL_OP_SEC_READ) begin
          out_byte = sec_rd_data_in;
          st_d.sec_byte = st_q.sec_byte + 8'h01;
        end else begin
          out_byte = {7'h00, st_q.lock[unit_idx]};
        end
        st_d.so = out_byte[7];
        st_d.tx_sh = {out_byte[6:0], 1'b0};
      end else begin
        st_d.so = st_q.tx_sh[7];
        st_d.tx_sh = {st_q.tx_sh[6:0], 1'b0};
      end
      st_d.tx_idx = st_q.tx_idx + 3'h1;
      st_d.so_oe = 1'b1;
    end

    // End of frame: execute write-type commands
    if (cs_rise && st_q.frame_ok) begin
      if (st_q.bit_cnt == `FSL_OPC_BITS) begin
        if (write_enable_latch_in) begin
          if (st_q.opcode == `FSL_OP_LOCK_ALL) begin
            st_d.lock = `FSL_LOCK_ALL_SET;
          end else if (st_q.opcode == `FSL_OP_UNLOCK_ALL) begin
            st_d.lock = `FSL_LOCK_ALL_CLR;
          end
        end
      end else if (st_q.bit_cnt == `FSL_ADDR_END) begin
        if (write_enable_latch_in) begin
          if (st_q.opcode == `FSL_OP_LOCK_ONE) begin
            st_d.lock[unit_idx] = 1'b1;
          end else if (st_q.opcode == `FSL_OP_UNLOCK_ONE) begin
            st_d.lock[unit_idx] = 1'b0;
          end
        end
      end
      if (st_q.bit_cnt >= `FSL_OPC_BITS) begin
        // Any whole command other than a bare 66h leaves reset disarmed
        st_d.armed = (st_q.opcode == `FSL_OP_RST_ARM) &&
                     (st_q.bit_cnt == `FSL_OPC_BITS);
        if (st_q.armed && st_q.opcode == `FSL_OP_RST_GO &&
            st_q.bit_cnt == `FSL_OPC_BITS) begin
          st_d.lock = `FSL_LOCK_ALL_SET;
          st_d.rec_cnt = 9'(`FSL_RST_CYCLES);
          st_d.rst_pulse = 1'b1;
        end
      end
      st_d.frame_ok = 1'b0;
    end

    if (cs_high) begin
      st_d.bit_cnt = 6'h00;
      st_d.tx_idx = 3'h0;
      st_d.so_oe = 1'b0;
      st_d.rd_ok = 1'b0;
    end
  end

  // ******************************************
  // State register
  // ******************************************
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      st_q <= '0;
      st_q.cs_s <= 3'h7;
      st_q.lock <= `FSL_LOCK_ALL_SET;
    end else begin
      st_q <= st_d;
    end
  end

  // ******************************************
  // User side
  // ******************************************
  assign spi.so = st_q.so;
  assign spi.so_oe = st_q.so_oe;
  assign sec_rd_addr_out = {st_q.sec_sel, st_q.sec_byte};
  assign lock_bits_out = st_q.lock;
  assign sw_reset_out = st_q.rst_pulse;
  assign recovering_out = (st_q.rec_cnt != 9'h000);
  assign protected_out = per_unit_lock_select_in ?
                         st_q.lock[prot_unit_in] : range_protect_in;

endmodule : fsl_dev

// ==== core/fsl_params.svh ====
// Constants shared by both ends of the flash lock/reset command link.
// Assumes a 10 MHz system clock and a serial clock made by the host end.
`ifndef FSL_PARAMS_SVH
`define FSL_PARAMS_SVH

// ******************************************
// Opcodes
// ******************************************
`define FSL_OP_SEC_READ 8'h48
`define FSL_OP_LOCK_ONE 8'h36
`define FSL_OP_UNLOCK_ONE 8'h39
`define FSL_OP_LOCK_READ 8'h3d
`define FSL_OP_LOCK_ALL 8'h7e
`define FSL_OP_UNLOCK_ALL 8'h98
`define FSL_OP_RST_ARM 8'h66
`define FSL_OP_RST_GO 8'h99

// ******************************************
// Frame bit counts
// ******************************************
`define FSL_OPC_BITS 6'h08
`define FSL_ADDR_END 6'h20
`define FSL_SEC_START 6'h28
`define FSL_ADDR_BITS 6'h18
`define FSL_DUMMY_BITS 6'h08

// ******************************************
// Address fields
// ******************************************
`define FSL_SEC_HI_MSB 23
`define FSL_SEC_HI_LSB 16
`define FSL_SEC_MID_MSB 11
`define FSL_SEC_MID_LSB 8
`define FSL_SEC_SEL_MSB 15
`define FSL_SEC_SEL_LSB 12
`define FSL_SEC_BYTE_MSB 7
`define FSL_SEC_HI_ZERO 8'h00
`define FSL_SEC_MID_ZERO 4'h0
`define FSL_SEC_SEL_MIN 4'h1
`define FSL_SEC_SEL_MAX 4'h3
`define FSL_LOCK_UNITS 32
`define FSL_LOCK_IDX_MSB 20
`define FSL_LOCK_IDX_LSB 16
`define FSL_LOCK_ALL_SET 32'hffff_ffff
`define FSL_LOCK_ALL_CLR 32'h0000_0000

// ******************************************
// Timing
// ******************************************
`define FSL_CLK_PERIOD_NS 100
`define FSL_T_RST_NS 30000
`define FSL_RST_CYCLES \
  ((`FSL_T_RST_NS + `FSL_CLK_PERIOD_NS - 1) / `FSL_CLK_PERIOD_NS)
`define FSL_HOST_DIV_LAST 3'h7

// ******************************************
// Host command registers
// ******************************************
`define FSL_HREG_CMD 4'h0
`define FSL_HREG_ADDR 4'h1
`define FSL_HREG_CTRL 4'h2
`define FSL_HREG_STAT 4'h3
`define FSL_HREG_RDATA 4'h4
`define FSL_CTRL_ADDR_EN 0
`define FSL_CTRL_DUMMY_EN 1
`define FSL_CTRL_LEN_MSB 15
`define FSL_CTRL_LEN_LSB 8

`endif

// ==== core/fsl_pkg.sv ====
// Types for the flash lock/reset command link: state records of both ends.
// Assumes fsl_params.svh is on the include path.
`include "fsl_params.svh"

package fsl_pkg;

  typedef enum logic [2:0] {
    FSL_H_IDLE,
    FSL_H_LOW,
    FSL_H_HIGH,
    FSL_H_TAIL,
    FSL_H_CSHI
  } fsl_host_state_t;

  typedef struct packed {
    logic [2:0] cs_s;
    logic [2:0] ck_s;
    logic [1:0] si_s;
    logic frame_ok;
    logic [5:0] bit_cnt;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic rd_ok;
    logic [7:0] tx_sh;
    logic [2:0] tx_idx;
    logic so;
    logic so_oe;
    logic [1:0] sec_sel;
    logic [7:0] sec_byte;
    logic [`FSL_LOCK_UNITS-1:0] lock;
    logic armed;
    logic [8:0] rec_cnt;
    logic rst_pulse;
  } fsl_dev_st_t;

  typedef struct packed {
    fsl_host_state_t state;
    logic [1:0] so_s;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic [2:0] div;
    logic [31:0] sh;
    logic [11:0] bit_no;
    logic [11:0] total;
    logic [5:0] tx_bits;
    logic [7:0] rx_sh;
    logic [7:0] rx_data;
    logic [7:0] rx_cnt;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [31:0] rdata;
  } fsl_host_st_t;

endpackage : fsl_pkg

// ==== core/fsl_spi_if.sv ====
// Serial link between the flash command end and the host end.
// Assumes both ends run on the same system clock; no clocking here.
`timescale 1ns/100ps

interface fsl_spi_if;
  logic cs_n;
  logic sclk;
  logic serial_in;
  logic so;
  logic so_oe;
  logic so_line;

  // Output pin floats high through a pull-up when nobody drives it
  assign so_line = so_oe ? so : 1'b1;

  modport dev (
    input cs_n,
    input sclk,
    input serial_in,
    output so,
    output so_oe
  );

  modport host (
    output cs_n,
    output sclk,
    output serial_in,
    input so_line
  );
endinterface : fsl_spi_if

// ==== core/fsl_host.sv ====
// Host end: builds one serial frame per software order and collects reads.
// Assumes software polls the status register; no interrupt.
`timescale 1ns/100ps
`include "fsl_params.svh"

module fsl_host (
  input wire logic ref_clk_in, // System clock, 10 MHz
  input wire logic reset_n_in, // Synchronous reset, active low
  fsl_spi_if.host spi, // Serial link to the flash end
  input wire logic [3:0] reg_addr_in, // Register index
  input wire logic [31:0] reg_wdata_in, // Write data
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  output logic [31:0] reg_rdata_out // Read data, cycle after strobe
);

  fsl_pkg::fsl_host_st_t st_q;
  fsl_pkg::fsl_host_st_t st_d;

  logic busy;
  logic [11:0] rx_pos;
  logic [7:0] rd_len;

  assign busy = (st_q.state != fsl_pkg::FSL_H_IDLE);
  assign rx_pos = st_q.bit_no - 12'(st_q.tx_bits);
  assign rd_len = reg_wdata_in[`FSL_CTRL_LEN_MSB:`FSL_CTRL_LEN_LSB];

  always_comb begin
    st_d = st_q;
    st_d.so_s = {st_q.so_s[0], spi.so_line};

    // ******************************************
    // Register port
    // ******************************************
    if (reg_wr_in) begin
      case (reg_addr_in)
        `FSL_HREG_CMD: st_d.opcode = reg_wdata_in[7:0];
        `FSL_HREG_ADDR: st_d.addr = reg_wdata_in[23:0];
        default: ;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        `FSL_HREG_CMD: st_d.rdata = {24'h000000, st_q.opcode};
        `FSL_HREG_ADDR: st_d.rdata = {8'h00, st_q.addr};
        `FSL_HREG_STAT: st_d.rdata = {16'h0000, st_q.rx_cnt, 7'h00, busy};
        `FSL_HREG_RDATA: st_d.rdata = {24'h000000, st_q.rx_data};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end else begin
      st_d.rdata = 32'h0000_0000;
    end

    // ******************************************
    // Frame engine, one serial half-period per eight clocks
    // ******************************************
    case (st_q.state)
      fsl_pkg::FSL_H_IDLE: begin
        if (reg_wr_in && reg_addr_in == `FSL_HREG_CTRL) begin
          st_d.tx_bits = `FSL_OPC_BITS +
            (reg_wdata_in[`FSL_CTRL_ADDR_EN] ? `FSL_ADDR_BITS : 6'h00) +
            (reg_wdata_in[`FSL_CTRL_DUMMY_EN] ? `FSL_DUMMY_BITS : 6'h00);
          st_d.total = 12'(st_d.tx_bits) + {1'b0, rd_len, 3'h0};
          st_d.sh = {st_q.opcode, st_q.addr};
          st_d.mosi = st_q.opcode[7];
          st_d.bit_no = 12'h000;
          st_d.rx_cnt = 8'h00;
          st_d.div = 3'h0;
          st_d.cs_n = 1'b0;
          st_d.state = fsl_pkg::FSL_H_LOW;
        end
      end
      fsl_pkg::FSL_H_LOW: begin
        st_d.div = st_q.div + 3'h1;
        if (st_q.div == `FSL_HOST_DIV_LAST) begin
          st_d.sclk = 1'b1;
          st_d.state = fsl_pkg::FSL_H_HIGH;
          if (st_q.bit_no >= 12'(st_q.tx_bits)) begin
            st_d.rx_sh = {st_q.rx_sh[6:0], st_q.so_s[1]};
            if (rx_pos[2:0] == 3'h7) begin
              st_d.rx_data = {st_q.rx_sh[6:0], st_q.so_s[1]};
              st_d.rx_cnt = st_q.rx_cnt + 8'h01;
            end
          end
        end
      end
      fsl_pkg::FSL_H_HIGH: begin
        st_d.div = st_q.div + 3'h1;
        if (st_q.div == `FSL_HOST_DIV_LAST) begin
          st_d.sclk = 1'b0;
          if (st_q.bit_no == st_q.total - 12'h001) begin
            st_d.state = fsl_pkg::FSL_H_TAIL;
          end else begin
            st_d.bit_no = st_q.bit_no + 12'h001;
            st_d.sh = {st_q.sh[30:0], 1'b0};
            st_d.mosi = st_q.sh[30];
            st_d.state = fsl_pkg::FSL_H_LOW;
          end
        end
      end
      fsl_pkg::FSL_H_TAIL: begin
        st_d.div = st_q.div + 3'h1;
        if (st_q.div == `FSL_HOST_DIV_LAST) begin
          st_d.cs_n = 1'b1;
          st_d.mosi = 1'b0;
          st_d.state = fsl_pkg::FSL_H_CSHI;
        end
      end
      fsl_pkg::FSL_H_CSHI: begin
        // Keeps chip select high long enough for the far synchroniser
        st_d.div = st_q.div + 3'h1;
        if (st_q.div == `FSL_HOST_DIV_LAST) begin
          st_d.state = fsl_pkg::FSL_H_IDLE;
        end
      end
      default: begin
        st_d.state = fsl_pkg::FSL_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      st_q <= '0;
      st_q.cs_n <= 1'b1;
      st_q.so_s <= 2'h3;
      st_q.state <= fsl_pkg::FSL_H_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign spi.cs_n = st_q.cs_n;
  assign spi.sclk = st_q.sclk;
  assign spi.serial_in = st_q.mosi;
  assign reg_rdata_out = st_q.rdata;

endmodule : fsl_host

// ==== dv/fsl_assertions.sv ====
// Concurrent checks on the serial link joining the two command ends.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/100ps
`include "fsl_params.svh"

module fsl_assertions (
  input wire logic ref_clk_in, // System clock
  input wire logic reset_n_in, // Synchronous reset, active low
  input wire logic cs_n, // Chip select, low active
  input wire logic sclk, // Serial clock
  input wire logic serial_in, // Host to device data
  input wire logic so, // Device data
  input wire logic so_oe, // Device drives so
  input wire logic so_line // Resolved output pin
);
  // ******************************************
  // Frame tracking
  // ******************************************
  logic sclk_q;
  logic [11:0] n_q;
  logic [7:0] op_q;
  logic rise;

  assign rise = sclk && !sclk_q;

  always_ff @(posedge ref_clk_in) begin
    sclk_q <= sclk;
    if (!reset_n_in || cs_n) begin
      n_q <= 12'h000;
    end else if (rise) begin
      n_q <= n_q + 12'h001;
    end
    // Opcode stays after the frame so covers can see it at cs rise
    if (rise && !cs_n && n_q < 12'h008) begin
      op_q <= {op_q[6:0], serial_in};
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // ******************************************
  // Checks
  // ******************************************
  oe_idle_a: assert property (cs_n [*8] |-> !so_oe)
    else $error("so_oe high with chip select idle");
  oe_end_a: assert property ($rose(cs_n) |-> ##[1:5] !so_oe)
    else $error("so_oe kept after chip select rise");
  oe_start_a: assert property ($rose(so_oe) |-> !cs_n &&
    ((op_q == `FSL_OP_SEC_READ && n_q == 12'h028) ||
     (op_q == `FSL_OP_LOCK_READ && n_q == 12'h020)))
    else $error("device output started at wrong bit count");
  so_edge_a: assert property (so_oe && $past(so_oe) && $changed(so) |->
    !sclk)
    else $error("device data changed while clock high");
  si_hold_a: assert property (!cs_n && sclk |-> $stable(serial_in))
    else $error("host data changed while clock high");
  clk_idle_a: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  clk_high_a: assert property (rise |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high time not eight cycles");
  lock_msb_a: assert property (rise && !cs_n &&
    op_q == `FSL_OP_LOCK_READ && n_q >= 12'h020 && n_q[2:0] != 3'h7 |->
    !so_line)
    else $error("lock status upper bit not zero");

  cover property ($rose(so_oe) && op_q == `FSL_OP_SEC_READ);
  cover property ($rose(so_oe) && op_q == `FSL_OP_LOCK_READ);
  cover property ($rose(cs_n) && n_q == 12'h008 && op_q == `FSL_OP_RST_ARM);
endmodule : fsl_assertions

// ==== dv/tb_flash_secreg_lock_reset_cmds.sv ====
// Self-checking bench: host end drives the flash end over the link.
// Assumes one shared clock; security bytes come from a bench model.
`timescale 1ns/100ps
`include "fsl_params.svh"
`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
  end

module tb_flash_secreg_lock_reset_cmds;
  logic ref_clk, reset_n, reg_wr, reg_rd, busy, write_enable_latch, sel, range_prot;
  logic sw_rst, recov, prot;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, lock_bits, exp_lock, rd;
  logic [4:0] prot_unit;
  logic [7:0] sec_data, b;
  logic [9:0] sec_addr;
  logic [1:0] s;
  int n_fail, total_checks, n_rst, rec_len, i, len, r0;
  logic [7:0] ops [8] = '{8'h98, 8'h39, 8'h98, 8'h36, 8'h36, 8'h7e,
                          8'h39, 8'h98};
  logic [23:0] bad [5] = '{24'h000010, 24'h004020, 24'h011030,
                           24'h001140, 24'h001000};

  fsl_spi_if u_fsl_spi_if ();
  fsl_dev u_fsl_dev (.ref_clk_in(ref_clk), .reset_n_in(reset_n),
    .spi(u_fsl_spi_if), .busy_in(busy), .write_enable_latch_in(write_enable_latch),
    .per_unit_lock_select_in(sel), .range_protect_in(range_prot),
    .prot_unit_in(prot_unit), .sec_rd_data_in(sec_data),
    .sec_rd_addr_out(sec_addr), .protected_out(prot),
    .lock_bits_out(lock_bits), .sw_reset_out(sw_rst),
    .recovering_out(recov));
  fsl_host u_fsl_host (.ref_clk_in(ref_clk), .reset_n_in(reset_n),
    .spi(u_fsl_spi_if), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata));
  fsl_assertions u_fsl_assertions (.ref_clk_in(ref_clk),
    .reset_n_in(reset_n), .cs_n(u_fsl_spi_if.cs_n),
    .sclk(u_fsl_spi_if.sclk), .serial_in(u_fsl_spi_if.serial_in),
    .so(u_fsl_spi_if.so), .so_oe(u_fsl_spi_if.so_oe),
    .so_line(u_fsl_spi_if.so_line));

  // Byte model never has its top bit set, so a refused read (pull-up
  // gives FFh) cannot be mistaken for data
  function automatic logic [7:0] sec_val(input logic [9:0] ad);
    return {1'b0, ad[6:0] + {ad[9:8], ad[7], 4'h0}};
  endfunction : sec_val

  function automatic logic [31:0] next_lock(input logic [31:0] m,
    input logic [7:0] op, input logic [4:0] u, input logic w);
    if (!w) return m;
    case (op)
      `FSL_OP_LOCK_ONE: m[u] = 1'b1;
      `FSL_OP_UNLOCK_ONE: m[u] = 1'b0;
      `FSL_OP_LOCK_ALL: m = `FSL_LOCK_ALL_SET;
      `FSL_OP_UNLOCK_ALL: m = `FSL_LOCK_ALL_CLR;
      default: ;
    endcase
    return m;
  endfunction : next_lock

  assign sec_data = sec_val(sec_addr);

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (sw_rst === 1'b1) n_rst++;
    if (recov === 1'b1) rec_len++;
  end

  task automatic bus_wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] ad, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : bus_rd

  task automatic frame(input logic [7:0] op, input logic [23:0] ad,
    input logic [31:0] ctrl);
    int k;
    logic [31:0] st;
    bus_wr(`FSL_HREG_CMD, {24'h000000, op});
    bus_wr(`FSL_HREG_ADDR, {8'h00, ad});
    bus_wr(`FSL_HREG_CTRL, ctrl);
    st = 32'h00000001;
    for (k = 0; k < 20000 && st[0] !== 1'b0; k++) begin
      bus_rd(`FSL_HREG_STAT, st);
    end
    `CHK("frame done", 1'b0, st[0])
    // Device must see chip select high a few cycles between frames
    repeat (8) @(posedge ref_clk);
  endtask : frame

  task automatic lock_op(input logic [7:0] op, input logic [4:0] u,
    input logic w);
    @(posedge ref_clk);
    write_enable_latch <= w;
    frame(op, {3'h0, u, 16'h0000}, {31'h0, op == `FSL_OP_LOCK_ONE ||
      op == `FSL_OP_UNLOCK_ONE});
    exp_lock = next_lock(exp_lock, op, u, w);
    `CHK("lock map", exp_lock, lock_bits)
    frame(`FSL_OP_LOCK_READ, {3'h0, u, 16'h0000}, 32'h00000101);
    bus_rd(`FSL_HREG_RDATA, rd);
    `CHK("lock read", {7'h00, exp_lock[u]}, rd[7:0])
    @(posedge ref_clk);
    prot_unit <= u;
    sel <= 1'b1;
    @(posedge ref_clk);
    #1;
    `CHK("unit protect", exp_lock[u], prot)
  endtask : lock_op

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    #8000000;
    n_fail++;
    $display("[FAIL] watchdog expected done seen hang");
    stop_test();
  end

  initial begin
    {reset_n, reg_wr, reg_rd, busy, write_enable_latch, range_prot} = 6'h00;
    {reg_addr, reg_wdata, prot_unit} = 41'h0;
    sel = 1'b1;
    {n_fail, total_checks, n_rst, rec_len} = 128'h0;
    void'($urandom(32'h185dd9b7));
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    // ******************************************
    // Defaults and protection source
    // ******************************************
    `CHK("reset locks", `FSL_LOCK_ALL_SET, lock_bits)
    exp_lock = `FSL_LOCK_ALL_SET;
    for (i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      sel <= 1'b0;
      range_prot <= i[0];
      @(posedge ref_clk);
      #1;
      `CHK("range protect", i[0], prot)
    end
    $display("test defaults done");
    for (i = 0; i < 8; i++) begin
      lock_op(ops[i], (i == 3) ? 5'h1f : 5'($urandom), ~i[2] | i[0] |
        i[1] | (i == 0 ? 1'b0 : 1'b1) & (i != 4));
    end
    $display("test locks done");
    // ******************************************
    // Security register reads
    // ******************************************
    for (i = 0; i < 10; i++) begin
      s = (i < 2) ? 2'h3 : 2'(1 + $urandom % 3);
      b = (i == 0) ? 8'hfe : (i == 1) ? 8'hff : 8'($urandom);
      len = (i == 0) ? 3 : (i == 1) ? 1 : 1 + $urandom % 4;
      frame(`FSL_OP_SEC_READ, {8'h00, 2'h0, s, 4'h0, b},
        {16'h0000, 8'(len), 8'h03});
      bus_rd(`FSL_HREG_RDATA, rd);
      `CHK("sec byte", sec_val({s, 8'(b + len - 1)}), rd[7:0])
      bus_rd(`FSL_HREG_STAT, rd);
      `CHK("sec count", 8'(len), rd[15:8])
    end
    for (i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      busy <= (i == 4);
      frame(`FSL_OP_SEC_READ, bad[i], 32'h00000203);
      bus_rd(`FSL_HREG_RDATA, rd);
      `CHK("refused read", 8'hff, rd[7:0])
    end
    @(posedge ref_clk);
    busy <= 1'b0;
    $display("test security done");
    // ******************************************
    // Pin and software reset
    // ******************************************
    lock_op(`FSL_OP_UNLOCK_ALL, 5'h00, 1'b1);
    // Mid-run pin reset with the map cleared must relock every unit
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    `CHK("pin reset locks", `FSL_LOCK_ALL_SET, lock_bits)
    exp_lock = `FSL_LOCK_ALL_SET;
    lock_op(`FSL_OP_UNLOCK_ALL, 5'h00, 1'b1);
    r0 = n_rst;
    rec_len = 0;
    frame(`FSL_OP_RST_ARM, 24'h000000, 32'h00000000);
    frame(`FSL_OP_RST_GO, 24'h000000, 32'h00000000);
    `CHK("reset pulse", r0 + 1, n_rst)
    `CHK("reset locks", `FSL_LOCK_ALL_SET, lock_bits)
    frame(`FSL_OP_UNLOCK_ALL, 24'h000000, 32'h00000000);
    `CHK("recovery lock", `FSL_LOCK_ALL_SET, lock_bits)
    for (i = 0; i < 1000 && recov !== 1'b0; i++) @(posedge ref_clk);
    `CHK("recovery len", 32'(`FSL_RST_CYCLES), rec_len)
    r0 = n_rst;
    frame(`FSL_OP_RST_ARM, 24'h000000, 32'h00000000);
    frame(`FSL_OP_LOCK_READ, 24'h000000, 32'h00000101);
    frame(`FSL_OP_RST_GO, 24'h000000, 32'h00000000);
    `CHK("disarmed", r0, n_rst)
    $display("test reset done");
    stop_test();
  end
endmodule : tb_flash_secreg_lock_reset_cmds
